/* bench/aqs_pins_model.sv */
// Port B pins behind an external four-way analog multiplexer.
// Assumes the mux address comes from the block's port A outputs.
`timescale 1ns/1ps
module aqs_pins_model
(
    input  wire logic [15:0] group_level,
    input  wire logic [1:0]  mux_addr,
    output logic      [3:0]  pin
);
    // pin levels: each pin shows the selected input of its group.
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            pin[k] = group_level[k * 4 + mux_addr];
    end
endmodule : aqs_pins_model

/* bench/aqs_status_checker.sv */
// Checker for decode, interrupt and APB behaviour of the status block.
// Assumes it is bound to aqs_status and sees only its ports.
`timescale 1ns/1ps
module aqs_status_checker
    import aqs_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [5:0]  channel_select_field,
    input wire logic [1:0]  sample_time_select,
    input wire logic [4:0]  sample_cycles,
    input wire aqs_channel_select_field_t   channel_select_field_decode,
    input wire logic [1:0]  port_a_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [5:0] ch;
    logic       map;
    assign ch = channel_select_field;
    assign map = paddr inside {ADDR_STATUS, ADDR_CONTROL, ADDR_MASK,
                               ADDR_PORTB, ADDR_EVSTAT};
    a_unmapped_err: assert property (psel && penable && !map
        |-> pslverr && prdata == 32'h0) else $error("unmapped no error");
    a_sample_time: assert property ($past(presetn) |-> sample_cycles
        == 5'h2 << $past(sample_time_select)) else $error("sample time");
    a_end_marker: assert property ($past(presetn) && $past(ch) == CHANNEL_SELECT_FIELD_EOQ
        |-> channel_select_field_decode.end_of_queue) else $error("end marker lost");
    a_ref_decode: assert property ($past(presetn) && $past(ch) >= CHANNEL_SELECT_FIELD_VRL
        && $past(ch) <= CHANNEL_SELECT_FIELD_VMID |-> channel_select_field_decode.src == SRC_REF)
        else $error("reference decode");
    a_direct_portb: assert property ($past(presetn) && !port_a_pin_oe[0]
        && $past(ch) < 6'h04 |-> channel_select_field_decode.src == SRC_PORT_B
        && channel_select_field_decode.index == $past(ch[2:0])) else $error("port b decode");
    a_mux_portb: assert property ($past(presetn) && port_a_pin_oe[0]
        && !$past(ch[5]) && !$past(ch[3]) |-> channel_select_field_decode.src == SRC_PORT_B
        && channel_select_field_decode.index == {1'b0, $past(ch[4]), $past(ch[0])})
        else $error("mux decode");
    a_oe_pair: assert property (port_a_pin_oe[0] == port_a_pin_oe[1])
        else $error("address enables differ");
    // Flags cannot drop by themselves, so a falling request needs a write.
    a_irq_fall: assert property ($fell(irq) |->
        $past(psel && penable && pwrite, 2)) else $error("irq fell alone");
    a_reset_quiet: assert property ($rose(presetn) |-> !irq &&
        sample_cycles == 5'h2) else $error("reset state");
endmodule : aqs_status_checker

bind aqs_status aqs_status_checker aqs_status_checker_i (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pslverr,
    .channel_select_field, .sample_time_select, .sample_cycles,
    .channel_select_field_decode, .port_a_pin_oe, .irq);

/* bench/aqs_status_tb.sv */
// Self-checking bench for the queued converter status block.
// Assumes the checker binds itself and the pin model stands on port B.
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module aqs_status_tb
    import aqs_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic pready, pslverr, rerr, irq;
    aqs_queue_ev_t q1_ev = '0, q2_ev = '0;
    logic [5:0] chs = 0;
    logic [1:0] sts = 0, pao, paoe;
    logic [4:0] sample_cycles;
    aqs_channel_select_field_t channel_select_field_decode;
    logic [3:0] pb;
    logic [15:0] grp = 16'h0F05;
    int n_mismatch = 0, check_count = 0;
    always #50 pclk = ~pclk;
    aqs_pins_model aqs_pins_model_i (.group_level(grp), .mux_addr(pao),
        .pin(pb));
    aqs_status aqs_status_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .q1_ev(q1_ev),
        .q2_ev(q2_ev), .channel_select_field(chs),
        .sample_time_select(sts), .sample_cycles(sample_cycles),
        .channel_select_field_decode(channel_select_field_decode), .port_b_pin_i(pb),
        .port_a_mux_oe_unused(2'h0), .port_a_pin_o(pao),
        .port_a_pin_oe(paoe), .irq(irq));
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic ev(input logic [6:0] e1, input logic [6:0] e2);
        @(posedge pclk);
        q1_ev <= aqs_queue_ev_t'(e1);
        q2_ev <= aqs_queue_ev_t'(e2);
        @(posedge pclk);
        q1_ev <= aqs_queue_ev_t'(e1 & 7'h0C);
        q2_ev <= aqs_queue_ev_t'(e2 & 7'h0C);
        repeat (2) @(posedge pclk);
    endtask : ev
    task automatic st(input logic [5:0] x);
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rdat[15:10], x)
    endtask : st
    task automatic t_regs();
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b0, 12'(12'h004 * i), 32'h0);
            `CHK(rdat, 32'h0)
        end
        apb(1'b0, 12'h020, 32'h0);
        `CHK({rerr, rdat}, 33'h100000000)
        $display("t_regs done");
    endtask : t_regs
    task automatic t_done();
        ev(7'h40, 7'h00);
        st(6'h20);
        `CHK(irq, 1'b0)
        apb(1'b1, ADDR_MASK, 32'hFC00);
        apb(1'b1, ADDR_CONTROL, 32'h05);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, ADDR_STATUS, 32'hFC00);
        apb(1'b1, ADDR_STATUS, 32'h0);
        st(6'h20);
        apb(1'b1, ADDR_STATUS, 32'h0);
        st(6'h00);
        `CHK(irq, 1'b0)
        ev(7'h00, 7'h40);
        `CHK(irq, 1'b1)
        st(6'h08);
        apb(1'b1, ADDR_STATUS, 32'h0);
        st(6'h00);
        $display("t_done done");
    endtask : t_done
    task automatic t_pause();
        apb(1'b1, ADDR_CONTROL, 32'h0A);
        ev(7'h20, 7'h20);
        `CHK(irq, 1'b1)
        st(6'h14);
        apb(1'b1, ADDR_STATUS, 32'h0);
        ev(7'h02, 7'h00);
        st(6'h10);
        apb(1'b1, ADDR_STATUS, 32'h0);
        st(6'h00);
        apb(1'b0, ADDR_EVSTAT, 32'h0);
        `CHK(rdat[3:0], 4'hF)
        apb(1'b1, ADDR_EVSTAT, 32'hF);
        apb(1'b0, ADDR_EVSTAT, 32'h0);
        `CHK(rdat[3:0], 4'h0)
        $display("t_pause done");
    endtask : t_pause
    task automatic t_tor();
        ev(7'h10, 7'h10);
        st(6'h00);
        ev(7'h18, 7'h00);
        st(6'h02);
        apb(1'b1, ADDR_STATUS, 32'h0);
        st(6'h00);
        ev(7'h09, 7'h14);
        st(6'h03);
        apb(1'b1, ADDR_STATUS, 32'h0);
        $display("t_tor done");
    endtask : t_tor
    task automatic t_decode();
        logic [5:0] c [7] = '{6'h00, 6'h03, CHANNEL_SELECT_FIELD_PA0, CHANNEL_SELECT_FIELD_PA4, CHANNEL_SELECT_FIELD_VRL,
                              CHANNEL_SELECT_FIELD_VMID, 6'h10};
        aqs_src_t s [7] = '{SRC_PORT_B, SRC_PORT_B, SRC_PORT_A, SRC_PORT_A,
                            SRC_REF, SRC_REF, SRC_RESERVED};
        for (int i = 0; i < 4; i++)
        begin
            sts <= 2'(i);
            repeat (2) @(posedge pclk);
            `CHK(sample_cycles, 5'h2 << i)
        end
        for (int i = 0; i < 7; i++)
        begin
            chs <= c[i];
            repeat (2) @(posedge pclk);
            `CHK(channel_select_field_decode.src, s[i])
        end
        apb(1'b0, ADDR_PORTB, 32'h0);
        `CHK(rdat[3:0], 4'h5)
        apb(1'b1, ADDR_CONTROL, 32'h20);
        apb(1'b0, ADDR_PORTB, 32'h0);
        `CHK(rdat[3:0], 4'h0)
        chs <= CHANNEL_SELECT_FIELD_EOQ;
        apb(1'b1, ADDR_CONTROL, 32'h10);
        `CHK(channel_select_field_decode.end_of_queue, 1'b1)
        chs <= 6'h12;
        repeat (2) @(posedge pclk);
        `CHK({paoe, pao}, 4'hD)
        `CHK({channel_select_field_decode.src, channel_select_field_decode.index}, {SRC_PORT_B, 3'h2})
        $display("t_decode done");
    endtask : t_decode
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_done();
        t_pause();
        t_tor();
        t_decode();
        report_and_stop();
    end
    // The tests need well under a thousand cycles; this bound cuts a hang.
    initial
    begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : aqs_status_tb

/* inc/aqs_pkg.sv */
// Package for the queued converter status and channel decode block.
// Assumes one converter clock and an APB register slave.
package aqs_pkg;

    localparam logic [11:0] ADDR_STATUS  = 12'h000;
    localparam logic [11:0] ADDR_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_MASK    = 12'h008;
    localparam logic [11:0] ADDR_PORTB   = 12'h00C;
    localparam logic [11:0] ADDR_EVSTAT  = 12'h010;

    localparam int BIT_DONE1  = 15;
    localparam int BIT_PAUSE1 = 14;
    localparam int BIT_DONE2  = 13;
    localparam int BIT_PAUSE2 = 12;
    localparam int BIT_TOR1   = 11;
    localparam int BIT_TOR2   = 10;

    localparam int CTL_DONE_IE1  = 0;
    localparam int CTL_PAUSE_IE1 = 1;
    localparam int CTL_DONE_IE2  = 2;
    localparam int CTL_PAUSE_IE2 = 3;
    localparam int CTL_MUX_MODE  = 4;
    localparam int CTL_PB_ANALOG = 5;

    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [5:0]  CONTROL_RESET = 6'h00;
    localparam logic [3:0]  EVENT_RESET   = 4'h0;

    localparam logic [5:0] CHANNEL_SELECT_FIELD_PA0    = 6'h34;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_PA1    = 6'h35;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_PA3    = 6'h37;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_PA4    = 6'h38;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_VRL    = 6'h3C;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_VRH    = 6'h3D;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_VMID   = 6'h3E;
    localparam logic [5:0] CHANNEL_SELECT_FIELD_EOQ    = 6'h3F;

    typedef enum logic [3:0] {
        SRC_PORT_B   = 4'h1,
        SRC_PORT_A   = 4'h2,
        SRC_REF      = 4'h4,
        SRC_RESERVED = 4'h8
    } aqs_src_t;

    typedef struct packed {
        aqs_src_t   src;
        logic [2:0] index;
        logic [1:0] mux_addr;
        logic       end_of_queue;
    } aqs_channel_select_field_t;

    typedef struct packed {
        logic done;
        logic pause;
        logic trigger;
        logic active;
        logic suspended;
        logic gate_early;
        logic eoq_gated;
    } aqs_queue_ev_t;

endpackage : aqs_pkg

/* verilog/aqs_status.sv */
// Status flags, interrupt requests and channel decode of a queued converter.
// Assumes queue sequencers on pclk give one-cycle event pulses and levels.
// Functional notes
// [R01] Four port B pins act as analog inputs 0 to 3 or a 4-bit digital port.
// [R02] A queue's done flag (bits 15, 13) sets when its last word's result lands.
// [R03] A set done flag with its done interrupt enable at 1 requests an interrupt; the code also needs its mask_q bit at 1.
// [R04] Done flag clears only on reset or a 0 write after it was read as 1.
// [R05] Done flags update whether or not the interrupt is enabled.
// [R06] A queue's pause flag (bits 14, 12) sets after a pause word's result lands.
// [R07] Queue 1's pause flag also sets when the gate closes before end of queue.
// [R08] A set pause flag with pause enable at 1 requests an interrupt; same clear. The code also needs its mask_q bit at 1.
// [R09] Trigger overrun flags (bits 11, 10) set only while the queue is active.
// [R10] Overrun sets on an unexpected trigger or second gated end of queue.
// [R11] A queue 2 trigger while it is suspended sets its overrun flag too.
// [R12] Sample time codes 00 to 11 give 2, 4, 8 and 16 converter clocks.
// [R13] Direct mode maps codes 0-3 to port B and 52,53,55,56 to port A pins.
// [R14] Codes 60, 61, 62 convert the references; 63 marks end of queue.
// [R15] Mux mode maps port B by 000XX0 patterns and drives port A 0-1 as address; the code maps every 0X0XXX code to port B.
// [R16] Any unassigned channel code is reserved with an undefined result.
// [R17] Writing 1 to a done, pause or overrun flag leaves it unchanged.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module aqs_status
    import aqs_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire aqs_queue_ev_t q1_ev,
    input  wire aqs_queue_ev_t q2_ev,
    input  wire logic [5:0]    channel_select_field,
    input  wire logic [1:0]    sample_time_select,
    output logic      [4:0]    sample_cycles,
    output aqs_channel_select_field_t          channel_select_field_decode,
    input  wire logic [3:0]    port_b_pin_i,
    input  wire logic [1:0]    port_a_mux_oe_unused,
    output logic      [1:0]    port_a_pin_o,
    output logic      [1:0]    port_a_pin_oe,
    output logic               irq
);

    logic [15:0]   status_q;
    logic [5:0]    control_q;
    logic [15:0]   mask_q;
    logic [5:0]    read_seen_q;
    logic [3:0]    pb_meta_q;
    logic [3:0]    pb_sync_q;
    logic [3:0]    event_q;
    logic [15:0]   set_vec;
    logic [15:0]   clr_vec;
    logic [15:0]   irq_src;
    logic          wr_en;
    logic          rd_en;
    logic          addr_ok;
    aqs_channel_select_field_t     channel_select_field_d;

    // Decode one channel code under the given multiplexing mode.
    function automatic aqs_channel_select_field_t decode_channel_select_field(input logic [5:0] code,
                                              input logic mux);
        aqs_channel_select_field_t r;
        r.src          = SRC_RESERVED;
        r.index        = 3'h0;
        r.mux_addr     = 2'h0;
        r.end_of_queue = 1'b0;
        // [R15] mux groups
        if (mux && code[5] == 1'b0 && code[3] == 1'b0)
        begin
            r.src      = SRC_PORT_B;
            r.index    = {1'b0, code[4], code[0]};
            r.mux_addr = code[2:1];
        end
        // [R13] direct port B
        else if (!mux && code[5:2] == 4'h0)
        begin
            r.src   = SRC_PORT_B;
            r.index = {1'b0, code[1:0]};
        end
        // [R13] port A inputs
        else if ((!mux && (code == CHANNEL_SELECT_FIELD_PA0 || code == CHANNEL_SELECT_FIELD_PA1))
                 || code == CHANNEL_SELECT_FIELD_PA3 || code == CHANNEL_SELECT_FIELD_PA4)
        begin
            r.src   = SRC_PORT_A;
            r.index = code[2:0];
        end
        // [R14] reference inputs
        else if (code == CHANNEL_SELECT_FIELD_VRL || code == CHANNEL_SELECT_FIELD_VRH || code == CHANNEL_SELECT_FIELD_VMID)
        begin
            r.src   = SRC_REF;
            r.index = code[2:0];
        end
        // [R14] end of queue
        else if (code == CHANNEL_SELECT_FIELD_EOQ)
        begin
            r.src          = SRC_REF;
            r.end_of_queue = 1'b1;
        end
        // [R16] reserved codes fall through as reserved.
        return r;
    endfunction : decode_channel_select_field

    assign addr_ok = (paddr == ADDR_STATUS) || (paddr == ADDR_CONTROL)
                     || (paddr == ADDR_MASK) || (paddr == ADDR_PORTB)
                     || (paddr == ADDR_EVSTAT);
    assign wr_en   = psel && penable && pwrite && addr_ok;
    assign rd_en   = psel && penable && !pwrite && addr_ok;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb
    begin
        set_vec = 16'h0000;
        // [R02] done on last result
        set_vec[BIT_DONE1]  = q1_ev.done;
        set_vec[BIT_DONE2]  = q2_ev.done;
        // [R06] [R07] pause events
        set_vec[BIT_PAUSE1] = q1_ev.pause || q1_ev.gate_early;
        set_vec[BIT_PAUSE2] = q2_ev.pause;
        // [R09] [R10] overrun while active
        set_vec[BIT_TOR1]   = q1_ev.active
                              && (q1_ev.trigger || q1_ev.eoq_gated);
        // [R11] suspended queue 2
        set_vec[BIT_TOR2]   = q2_ev.trigger
                              && (q2_ev.active || q2_ev.suspended);
    end

    always_comb
    begin
        clr_vec = 16'h0000;
        if (wr_en && paddr == ADDR_STATUS)
        begin
            // [R04] [R08] read-then-zero clear
            clr_vec[BIT_DONE1]  = read_seen_q[0] && !pwdata[BIT_DONE1];
            clr_vec[BIT_PAUSE1] = read_seen_q[1] && !pwdata[BIT_PAUSE1];
            clr_vec[BIT_DONE2]  = read_seen_q[2] && !pwdata[BIT_DONE2];
            clr_vec[BIT_PAUSE2] = read_seen_q[3] && !pwdata[BIT_PAUSE2];
            // [R10] zero write clears overrun
            clr_vec[BIT_TOR1]   = !pwdata[BIT_TOR1];
            clr_vec[BIT_TOR2]   = !pwdata[BIT_TOR2];
        end
    end

    // [R05] [R17] Flags set regardless of enables; a new event beats a clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status_q <= STATUS_RESET;
        else
            status_q <= set_vec | (status_q & ~clr_vec);
    end

    // Remembers which done and pause flags software saw as 1, so a blind zero write spares them.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            read_seen_q <= 6'h00;
        else if (rd_en && paddr == ADDR_STATUS)
            read_seen_q <= {2'b00, status_q[BIT_PAUSE2], status_q[BIT_DONE2],
                            status_q[BIT_PAUSE1], status_q[BIT_DONE1]};
        else if (wr_en && paddr == ADDR_STATUS)
            read_seen_q <= 6'h00;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_q <= CONTROL_RESET;
        else if (wr_en && paddr == ADDR_CONTROL)
            control_q <= pwdata[5:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mask_q <= 16'h0000;
        else if (wr_en && paddr == ADDR_MASK)
            mask_q <= pwdata[15:0];
    end

    // Queue 1 and 2 event trace, cleared by writing one.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_q <= EVENT_RESET;
        else
            event_q <= {q2_ev.pause, q2_ev.done, q1_ev.pause, q1_ev.done}
                       | (event_q & ~((wr_en && paddr == ADDR_EVSTAT)
                                      ? pwdata[3:0] : 4'h0));
    end

    // [R01] Port B pins synchronised for the digital port.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pb_meta_q <= 4'h0;
            pb_sync_q <= 4'h0;
        end
        else
        begin
            pb_meta_q <= port_b_pin_i;
            pb_sync_q <= pb_meta_q;
        end
    end

    // [R03] [R08] Interrupt gating by enables, then by the generic mask.
    always_comb
    begin
        irq_src             = 16'h0000;
        irq_src[BIT_DONE1]  = control_q[CTL_DONE_IE1];
        irq_src[BIT_PAUSE1] = control_q[CTL_PAUSE_IE1];
        irq_src[BIT_DONE2]  = control_q[CTL_DONE_IE2];
        irq_src[BIT_PAUSE2] = control_q[CTL_PAUSE_IE2];
        irq_src[BIT_TOR1]   = 1'b1;
        irq_src[BIT_TOR2]   = 1'b1;
        irq_src             = irq_src & mask_q & status_q;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |irq_src;
    end

    assign channel_select_field_d = decode_channel_select_field(channel_select_field, control_q[CTL_MUX_MODE]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_select_field_decode   <= '{SRC_RESERVED, 3'h0, 2'h0, 1'b0};
            sample_cycles <= 5'h02;
            port_a_pin_o  <= 2'h0;
            port_a_pin_oe <= 2'h0;
        end
        else
        begin
            channel_select_field_decode   <= channel_select_field_d;
            // [R12] sample time 2,4,8,16
            sample_cycles <= 5'(5'h02 << sample_time_select);
            // [R15] mux address pins
            port_a_pin_o  <= channel_select_field_d.mux_addr;
            port_a_pin_oe <= {2{control_q[CTL_MUX_MODE]}};
        end
    end

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (rd_en)
        begin
            case (paddr)
                ADDR_STATUS:  prdata[15:0] = status_q;
                ADDR_CONTROL: prdata[5:0]  = control_q;
                ADDR_MASK:    prdata[15:0] = mask_q;
                ADDR_PORTB:   prdata[3:0]  = control_q[CTL_PB_ANALOG]
                                             ? 4'h0 : pb_sync_q;
                ADDR_EVSTAT:  prdata[3:0]  = event_q;
                default:      prdata       = 32'h0000_0000;
            endcase
        end
    end

endmodule : aqs_status
